//--- core/cdsr_regs.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Behaviour
// R1: Status byte: type preview[7:4], type bit 3, variant bit 2, next variant[1:0].
// R2: Type/variant 00 type 1, 10 type 2 var 1, x1 type 2 var 2 or uncorrectable.
// R3: Reported type bit always comes from the control type request bit.
// R4: Variant from control bit when auto request is 0, else from header byte.
// R5: Variant forced to 1 on illegal sync, long block or type 2 variant 2.
// R6: Variant forced on submode error, and on type mismatch/byte error if checking.
// R7: Next variant preview: 00 var 0, 01 var 1, upper bit 1 variant byte error.
// R8: Type preview: top = OR of byte bits 7..3 and erasure; others bit OR erasure.
// R9: Preview 0000..0111 types 0..7; top bit set means above 7 or error.
// R10: Reading the interrupt status register clears a pending decoder interrupt.
// R11: Invalid bit 0 while registers valid, 1 once all decoder registers were read.
// R12: ECC done bit 1 when correction was performed on the current block.
// R13: Any write to soft reset reinitialises all registers and sets host mode.
// R14: After hardware reset host select reads 111 until software picks a mode.
// R15: After hardware reset host pins stay tri-state unless host read strobe is low.
// R16: Host select 000 mode A, 001 ATAPI, 010 mode B, 011 all pins tri-state.
// R17: Subcode block address is 10 bits over low and high registers, first 1 kbyte.
// R18: Config bit 7 picks serial format: 0 I2S, 1 EIAJ.
// R19: Config bits 6:5 oversampling: 00 none, 01 two times, 10 four times.
// R20: Bit 4 subcode format V4/EIAJ, bit 3 port enable, bit 2 cooked/raw.
// R21: Config bit 1 selects buffer RAM test mode.
// R22: Subcode recovery times off bit clock; software sets oversampling to match.
// R23: Illegal sync flag set on sync at count 0..1174 or 1176 on when retimed.
// R24: Erasure flag reflects the erasure input from the signal processor.
// R25: Reserved bits read zero and ignore writes.
module cdsr_regs (
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    input  wire logic                         clk_en,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [cdsr_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Decoder side
    input  wire cdsr_pkg::cdsr_dec_evt_t      dec_evt,
    input  wire logic                         erasure_input,
    output logic                              decoder_interrupt,
    // Host side
    input  wire logic                         host_read_strobe_n,
    output logic      [2:0]                   host_select,
    output logic                              host_mode_a,
    output logic                              host_atapi,
    output logic                              host_mode_b,
    output logic                              host_pins_oe_n,
    output logic                              soft_reset_pulse,
    // Configuration out
    output cdsr_pkg::cdsr_in_cfg_t            input_cfg,
    output logic      [9:0]                   subcode_block_address
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] cfg;
    logic [2:0] ctrl_one;
    logic       auto_variant_request;
    logic [9:0] sub_addr;
    logic [3:0] type_preview;
    logic       type_bit;
    logic       variant_bit;
    logic [1:0] next_variant;
    logic       ecc_done_flag;
    logic       registers_invalid_flag;
    logic [1:0] read_seen;
    logic       illegal_sync_flag;
    logic       erasure_flag;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        access     = psel & penable;
    wire        complete   = access & pready;
    wire        wr_en      = complete & pwrite;
    wire        rd_en      = complete & ~pwrite;
    wire        hit_status = paddr == cdsr_pkg::OFS_SECTOR_STATUS;
    wire        hit_irq    = paddr == cdsr_pkg::OFS_IRQ_STATUS;
    wire        hit_reset  = paddr == cdsr_pkg::OFS_SOFT_RESET;
    wire        hit_sub_lo = paddr == cdsr_pkg::OFS_SUB_ADDR_LO;
    wire        hit_sub_hi = paddr == cdsr_pkg::OFS_SUB_ADDR_HI;
    wire        hit_cfg    = paddr == cdsr_pkg::OFS_INPUT_CFG;
    wire        hit_c1     = paddr == cdsr_pkg::OFS_CTRL_ONE;
    wire        hit_c0     = paddr == cdsr_pkg::OFS_CTRL_ZERO;
    wire        mapped     = hit_status | hit_irq | hit_reset | hit_sub_lo | hit_sub_hi
                           | hit_cfg | hit_c1 | hit_c0;
    wire        sw_init    = wr_en & hit_reset;                               // [R13]
    wire        irq_read   = rd_en & hit_irq;
    wire        stat_read  = rd_en & hit_status;

    // ------------------------------------------------------------
    // Decoder events
    // ------------------------------------------------------------
    wire        block_end  = dec_evt.block_end;
    wire        type_req   = ctrl_one[cdsr_pkg::POS_TYPE_BIT - 1];
    wire        var_req    = ctrl_one[cdsr_pkg::POS_VARIANT_BIT - 1];
    wire        type_check = ctrl_one[cdsr_pkg::POS_TYPE_CHECK - 1];
    wire        sync_bad   = dec_evt.sync_found & dec_evt.retimed
                           & ((dec_evt.word_count <= cdsr_pkg::SYNC_LAST_LOW)
                           | (dec_evt.word_count >= cdsr_pkg::SYNC_FIRST_HIGH)); // [R23]
    wire        illegal_sync_flag_now = illegal_sync_flag | sync_bad;
    wire        erase_now  = erasure_flag | erasure_input;                    // [R24]
    wire        var_pick   = auto_variant_request ? dec_evt.hdr_variant : var_req; // [R4]
    wire        type2_var2 = type_req & (var_req | dec_evt.hdr_variant);
    wire        force_var  = illegal_sync_flag_now | dec_evt.long_block | type2_var2     // [R5]
                           | dec_evt.submode_err                              // [R6]
                           | (type_check & (dec_evt.type_mismatch | dec_evt.type_byte_err));
    wire        next_var   = var_pick | force_var;
    wire [3:0]  next_prev  = preview(dec_evt.next_type_byte, erase_now);     // [R8]

    // ------------------------------------------------------------
    // Host select decode
    // ------------------------------------------------------------
    wire [2:0]  hsel_next  = sw_init ? pwdata[2:0] : host_select;
    wire        awaiting   = hsel_next == cdsr_pkg::HSEL_HW_RESET;
    wire        next_oe_n  = awaiting ? host_read_strobe_n                    // [R15]
                           : ~((hsel_next == cdsr_pkg::HSEL_MODE_A)
                           | (hsel_next == cdsr_pkg::HSEL_ATAPI)
                           | (hsel_next == cdsr_pkg::HSEL_MODE_B));           // [R16]

    // Preview bits; an erasure marks the whole byte unreliable
    function automatic logic [3:0] preview(input logic [7:0] b, input logic e);
        preview = {(|b[7:3]) | e, b[2] | e, b[1] | e, b[0] | e};
    endfunction

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [7:0]  stat_byte  = {type_preview, type_bit, variant_bit, next_variant}; // [R1]
    wire [7:0]  irq_byte   = {registers_invalid_flag, 1'b0, ecc_done_flag, 5'h00}; // [R25]
    wire [7:0]  rd_byte    = hit_status ? stat_byte
                           : hit_irq    ? irq_byte
                           : hit_sub_lo ? sub_addr[7:0]
                           : hit_sub_hi ? {6'h00, sub_addr[9:8]}                 // [R17]
                           : hit_cfg    ? cfg
                           : hit_c1     ? {4'h0, ctrl_one, 1'b0}
                           : hit_c0     ? {7'h00, auto_variant_request}
                           : 8'h00;

    // ------------------------------------------------------------
    // APB answer: one wait state, registered
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            prdata  <= (access & ~pready & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg                  <= cdsr_pkg::INPUT_CFG_RESET;
            ctrl_one             <= 3'h0;
            auto_variant_request <= 1'b0;
            sub_addr             <= cdsr_pkg::SUB_ADDR_RESET;
        end else if (clk_en) begin
            if (sw_init) begin                                                // [R13]
                cfg                  <= cdsr_pkg::INPUT_CFG_RESET;
                ctrl_one             <= 3'h0;
                auto_variant_request <= 1'b0;
                sub_addr             <= cdsr_pkg::SUB_ADDR_RESET;
            end else if (wr_en) begin
                if (hit_cfg)
                    cfg <= pwdata[7:0] & cdsr_pkg::INPUT_CFG_MASK;            // [R25]
                if (hit_c1)
                    ctrl_one <= pwdata[3:1];
                if (hit_c0)
                    auto_variant_request <= pwdata[cdsr_pkg::POS_AUTO_VARIANT];
                if (hit_sub_lo)
                    sub_addr[7:0] <= pwdata[7:0];                             // [R17]
                if (hit_sub_hi)
                    sub_addr[9:8] <= pwdata[cdsr_pkg::POS_SUB_HI_MSB:0];      // [R17]
            end
        end
    end

    // ------------------------------------------------------------
    // Host select; a hardware reset or a soft reset write of 111 brings back the wait code
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_select      <= cdsr_pkg::HSEL_HW_RESET;                      // [R14]
            host_pins_oe_n   <= 1'b1;                                         // [R15]
            host_mode_a      <= 1'b0;
            host_atapi       <= 1'b0;
            host_mode_b      <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            host_select      <= hsel_next;                                    // [R13]
            host_pins_oe_n   <= next_oe_n;
            host_mode_a      <= hsel_next == cdsr_pkg::HSEL_MODE_A;           // [R16]
            host_atapi       <= hsel_next == cdsr_pkg::HSEL_ATAPI;            // [R16]
            host_mode_b      <= hsel_next == cdsr_pkg::HSEL_MODE_B;           // [R16]
            soft_reset_pulse <= sw_init;
        end
    end

    // ------------------------------------------------------------
    // Frame status, captured at block end
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            type_preview  <= 4'h0;
            type_bit      <= 1'b0;
            variant_bit   <= 1'b0;
            next_variant  <= 2'h0;
            ecc_done_flag <= 1'b0;
        end else if (clk_en) begin
            if (sw_init) begin
                type_preview  <= 4'h0;
                type_bit      <= 1'b0;
                variant_bit   <= 1'b0;
                next_variant  <= 2'h0;
                ecc_done_flag <= 1'b0;
            end else if (block_end) begin
                type_preview  <= next_prev;                                   // [R9]
                type_bit      <= type_req;                                    // [R3]
                variant_bit   <= next_var;                                    // [R2]
                next_variant  <= {dec_evt.next_variant_err,
                                  dec_evt.next_variant_bit};                  // [R7]
                ecc_done_flag <= dec_evt.ecc_done;                            // [R12]
            end
        end
    end

    // ------------------------------------------------------------
    // Per-block sticky flags; a new event beats the block-end clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            illegal_sync_flag <= 1'b0;
            erasure_flag      <= 1'b0;
        end else if (clk_en) begin
            if (sw_init) begin
                illegal_sync_flag <= 1'b0;
                erasure_flag      <= 1'b0;
            end else begin
                illegal_sync_flag <= sync_bad | (illegal_sync_flag & ~block_end); // [R23]
                erasure_flag      <= erasure_input | (erasure_flag & ~block_end); // [R24]
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt and validity tracking
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            decoder_interrupt      <= 1'b0;
            registers_invalid_flag <= 1'b1;
            read_seen              <= 2'h0;
        end else if (clk_en) begin
            if (sw_init) begin
                decoder_interrupt      <= 1'b0;
                registers_invalid_flag <= 1'b1;
                read_seen              <= 2'h0;
            end else if (block_end) begin
                decoder_interrupt      <= 1'b1;                               // [R10]
                registers_invalid_flag <= 1'b0;                               // [R11]
                read_seen              <= 2'h0;
            end else begin
                if (irq_read)
                    decoder_interrupt <= 1'b0;                                // [R10]
                read_seen <= read_seen | {irq_read, stat_read};
                if ((read_seen | {irq_read, stat_read}) == cdsr_pkg::READ_ALL_MASK)
                    registers_invalid_flag <= 1'b1;                           // [R11]
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration outputs; subcode recovery times off bit clock, oversampling set to match
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_cfg             <= '0;
            subcode_block_address <= cdsr_pkg::SUB_ADDR_RESET;
        end else if (clk_en) begin
            input_cfg.serial_input_format  <= cfg[7];                         // [R18]
            input_cfg.oversample_hi        <= cfg[6];                         // [R19] [R22]
            input_cfg.oversample_lo        <= cfg[5];                         // [R19]
            input_cfg.subcode_input_format <= cfg[4];                         // [R20]
            input_cfg.subcode_port_enable  <= cfg[3];                         // [R20]
            input_cfg.subcode_raw_select   <= cfg[2];                         // [R20]
            input_cfg.buffer_ram_test      <= cfg[1];                         // [R21]
            subcode_block_address          <= sub_addr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_type_from_ctrl: assert property ( // [R3]
        clk_en && block_end && !sw_init |=> type_bit == $past(type_req))
        else $error("type bit not taken from control");

    chk_variant_forced: assert property ( // [R5]
        clk_en && block_end && !sw_init && (dec_evt.long_block || sync_bad) |=> variant_bit)
        else $error("variant not forced on illegal sync");

    chk_variant_check: assert property ( // [R6]
        clk_en && block_end && !sw_init && type_check && dec_evt.type_mismatch
        |=> variant_bit)
        else $error("variant not forced on type mismatch");

    chk_preview_erase: assert property ( // [R8]
        clk_en && block_end && !sw_init && erasure_input |=> type_preview == 4'hF)
        else $error("erasure did not mark preview");

    chk_irq_read_clr: assert property ( // [R10]
        clk_en && irq_read && !block_end && !sw_init |=> !decoder_interrupt)
        else $error("interrupt not cleared by status read");

    chk_valid_after_irq: assert property ( // [R11]
        clk_en && block_end && !sw_init |=> !registers_invalid_flag && decoder_interrupt)
        else $error("registers not valid after interrupt");

    chk_invalid_all_read: assert property ( // [R11]
        clk_en && !block_end && !sw_init && stat_read && read_seen[1] |=> registers_invalid_flag)
        else $error("invalid flag not raised after all reads");

    chk_soft_reset_sel: assert property ( // [R13]
        clk_en && sw_init |=> host_select == $past(pwdata[2:0]) && soft_reset_pulse
                              && cfg == cdsr_pkg::INPUT_CFG_RESET)
        else $error("soft reset did not select host");

    chk_tristate_wait: assert property ( // [R15]
        clk_en && host_select == cdsr_pkg::HSEL_HW_RESET && !sw_init && host_read_strobe_n
        |=> host_pins_oe_n)
        else $error("host pins driven while waiting");

    chk_unknown_host: assert property ( // [R16]
        host_select == cdsr_pkg::HSEL_UNKNOWN ##1 host_select == cdsr_pkg::HSEL_UNKNOWN
        |-> host_pins_oe_n && !host_atapi)
        else $error("unknown host drove pins");

    chk_cfg_reserved: assert property ( // [R25]
        cfg[0] == 1'b0)
        else $error("reserved config bit set");

    chk_apb_wait: assert property (
        access && !pready |=> pready ##1 !pready)
        else $error("APB answer timing wrong");

    chk_ecc_done_cap: assert property ( // [R12]
        clk_en && block_end && !sw_init |=> ecc_done_flag == $past(dec_evt.ecc_done))
        else $error("ECC done flag not captured");

    chk_next_variant: assert property ( // [R7]
        clk_en && block_end && !sw_init
        |=> next_variant == {$past(dec_evt.next_variant_err), $past(dec_evt.next_variant_bit)})
        else $error("next variant preview wrong");

    chk_manual_variant: assert property ( // [R4]
        clk_en && block_end && !sw_init && !auto_variant_request && !force_var
        |=> variant_bit == $past(var_req))
        else $error("variant not taken from control bit");

    chk_unmapped_err: assert property ( // [R25]
        clk_en && access && !pready && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

endmodule

//--- common/cdsr_pkg.sv
package cdsr_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses on APB
    // ------------------------------------------------------------
    localparam int          ADDR_W             = 8;
    localparam logic [7:0]  OFS_SECTOR_STATUS  = 8'h00;
    localparam logic [7:0]  OFS_IRQ_STATUS     = 8'h04;
    localparam logic [7:0]  OFS_SOFT_RESET     = 8'h08;
    localparam logic [7:0]  OFS_SUB_ADDR_LO    = 8'h0C;
    localparam logic [7:0]  OFS_SUB_ADDR_HI    = 8'h10;
    localparam logic [7:0]  OFS_INPUT_CFG      = 8'h14;
    localparam logic [7:0]  OFS_CTRL_ONE       = 8'h18;
    localparam logic [7:0]  OFS_CTRL_ZERO      = 8'h1C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          POS_TYPE_BIT       = 3;
    localparam int          POS_VARIANT_BIT    = 2;
    localparam int          POS_TYPE_CHECK     = 1;
    localparam int          POS_AUTO_VARIANT   = 0;
    localparam int          POS_INVALID        = 7;
    localparam int          POS_ECC_DONE       = 5;
    localparam int          POS_SUB_HI_MSB     = 1;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [2:0]  HSEL_HW_RESET      = 3'h7;
    localparam logic [2:0]  HSEL_MODE_A        = 3'h0;
    localparam logic [2:0]  HSEL_ATAPI         = 3'h1;
    localparam logic [2:0]  HSEL_MODE_B        = 3'h2;
    localparam logic [2:0]  HSEL_UNKNOWN       = 3'h3;
    localparam logic [7:0]  INPUT_CFG_RESET    = 8'h00;
    localparam logic [7:0]  INPUT_CFG_MASK     = 8'hFE;
    localparam logic [7:0]  CTRL_ONE_MASK      = 8'h0E;
    localparam logic [7:0]  CTRL_ZERO_MASK     = 8'h01;
    localparam logic [9:0]  SUB_ADDR_RESET     = 10'h000;
    localparam logic [1:0]  READ_ALL_MASK      = 2'h3;

    // ------------------------------------------------------------
    // Sync window counts
    // ------------------------------------------------------------
    localparam logic [10:0] SYNC_LAST_LOW      = 11'h496;
    localparam logic [10:0] SYNC_FIRST_HIGH    = 11'h498;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        block_end;
        logic        ecc_done;
        logic        sync_found;
        logic [10:0] word_count;
        logic        retimed;
        logic        long_block;
        logic        hdr_variant;
        logic        submode_err;
        logic        type_mismatch;
        logic        type_byte_err;
        logic [7:0]  next_type_byte;
        logic        next_variant_bit;
        logic        next_variant_err;
    } cdsr_dec_evt_t;

    typedef struct packed {
        logic       serial_input_format;
        logic       oversample_hi;
        logic       oversample_lo;
        logic       subcode_input_format;
        logic       subcode_port_enable;
        logic       subcode_raw_select;
        logic       buffer_ram_test;
    } cdsr_in_cfg_t;

endpackage

//--- dv/cdsr_cpu_model.sv
`timescale 1ns/1ps
module cdsr_cpu_model (
    input  wire logic        ref_clk, pready, pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel, penable, pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [8:0] q);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = {pslverr, prdata[7:0]};
        {psel, penable} <= 2'b00;
    endtask
endmodule

//--- dv/test_cdsr_regs.sv
`timescale 1ns/1ps
module test_cdsr_regs;
    logic ref_clk = 1'b0, host_read_strobe_n = 1'b1, rst_n, erasure_input, psel, penable;
    logic pwrite, pready, pslverr, decoder_interrupt, host_atapi, host_pins_oe_n;
    logic clk_en = 1'b1, host_mode_a, host_mode_b, soft_reset_pulse;
    logic [2:0]  host_select;
    logic [7:0]  paddr;
    logic [8:0]  q;
    logic [9:0]  subcode_block_address;
    logic [31:0] pwdata, prdata;
    cdsr_pkg::cdsr_dec_evt_t ev;
    cdsr_pkg::cdsr_in_cfg_t  input_cfg;
    int failures = 0, check_count = 0;
    cdsr_regs dut (.*, .dec_evt(ev));
    cdsr_cpu_model cpu (.*);
    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        #100us failures++;
        conclude();
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        @(negedge ref_clk);
        check_count++;
        failures += int'(s !== e);
        if (s !== e) $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d, input logic [8:0] e);
        cpu.xfer(w, a, d, q);
        chk($sformatf("reg %0h", a), 32'(e), 32'(q));
    endtask
    task automatic blk(input logic [7:0] ty, input logic lb, nv, er);
        @(posedge ref_clk);
        ev <= '{block_end: 1'b1, ecc_done: 1'b1, long_block: lb, next_type_byte: ty,
            next_variant_bit: nv, default: '0};
        erasure_input <= er;
        @(posedge ref_clk);
        {ev, erasure_input} <= '0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        {rst_n, erasure_input, ev} = '0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk("hsel", 3'h7, host_select);
        chk("oe_n", 1'b1, host_pins_oe_n);
        @(posedge ref_clk);
        host_read_strobe_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        host_read_strobe_n <= 1'b1;
        chk("oe_n", 1'b0, host_pins_oe_n);
        bus(1'b1, 8'h14, 8'hDF, 9'h000);
        bus(1'b0, 8'h14, 8'h00, 9'h0DE);
        chk("cfg", 7'h6F, input_cfg);
        bus(1'b1, 8'h10, 8'hFF, 9'h000);
        bus(1'b0, 8'h10, 8'h00, 9'h003);
        chk("sub", 10'h300, subcode_block_address);
        bus(1'b1, 8'h18, 8'h08, 9'h000);
        blk(8'h02, 1'b0, 1'b1, 1'b0);
        chk("irq", 1'b1, decoder_interrupt);
        bus(1'b0, 8'h04, 8'h00, 9'h020);
        chk("irq", 1'b0, decoder_interrupt);
        bus(1'b0, 8'h00, 8'h00, 9'h029);
        bus(1'b0, 8'h04, 8'h00, 9'h0A0);
        blk(8'h02, 1'b1, 1'b0, 1'b1);
        bus(1'b0, 8'h00, 8'h00, 9'h0FC);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        blk(8'h00, 1'b0, 1'b0, 1'b0);
        clk_en <= 1'b1;
        bus(1'b0, 8'h00, 8'h00, 9'h0FC);
        bus(1'b0, 8'h20, 8'h00, 9'h100);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'h08, 8'(c), 9'h000);
            chk("pulse", 1'b1, soft_reset_pulse);
            chk("hsel", 32'(c), host_select);
            chk("oe_n", c == 3, host_pins_oe_n);
            chk("mode", {c==0, c==1, c==2}, {host_mode_a, host_atapi, host_mode_b});
        end
        bus(1'b0, 8'h14, 8'h00, 9'h000);
        conclude();
    end
endmodule
